// ---- hw/memk_event_mask.sv ----
// Interrupt and event-pin mask logic of the metering front end.
// Behaviour
// - With interrupt-enable bit 6 set, a missing Phase A zero crossing raises the interrupt.
// - Interrupt-enable bits 4, 2, 1, 0 interrupt when any phase enters or leaves no load.
// - With event bit 16 set, the event pin goes low when new waveform samples are ready.
// - With event bit 14 set, the pin goes low while any fundamental reactive phase is no load.
// - Event bits 12, 11, 10 drive the pin low for apparent, reactive, active no load.
// - Event bits 9 to 6 drive the pin low if the last pulse on outputs 4 to 1 was negative.
// - Each negative indication is refreshed only on the falling edge of its pulse output.
`timescale 1ns/100ps
module memk_event_mask
  import memk_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Register access
  input wire memk_reg_req_t I_REG_REQ,
  output logic [31:0] O_REG_RDATA,
  // Metering conditions
  input wire logic I_ZX_TIMEOUT_A,
  input wire logic I_WAVE_READY,
  input wire memk_noload_t I_NOLOAD,
  input wire logic [MEMK_NUM_PULSE-1:0] I_PULSE_OUT,
  input wire logic [MEMK_NUM_PULSE-1:0] I_PULSE_NEGATIVE,
  // Outputs to the host
  output logic O_IRQ_N,
  output logic O_EVENT_N
);

  logic [31:0] int_en_q;
  logic [31:0] int_en_d;
  logic [31:0] evt_en_q;
  logic [31:0] evt_en_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  memk_noload_t noload_q;
  logic irq_q;
  logic irq_d;
  logic event_q;
  logic event_d;
  logic [3:0] nl_any;
  logic [3:0] nl_change;
  logic [MEMK_NUM_PULSE-1:0] pulse_neg;

  // Register file: reserved bits are never stored, so they read as zero.
  always_comb begin
    int_en_d = int_en_q;
    evt_en_d = evt_en_q;
    rdata_d = rdata_q;
    if (I_REG_REQ.wr && I_REG_REQ.addr == MEMK_INT_EN2_ADDR) begin
      int_en_d = I_REG_REQ.wdata & MEMK_INT_EN2_WMASK;
    end
    if (I_REG_REQ.wr && I_REG_REQ.addr == MEMK_EVT_EN_ADDR) begin
      evt_en_d = I_REG_REQ.wdata & MEMK_EVT_EN_WMASK;
    end
    if (I_REG_REQ.rd) begin
      if (I_REG_REQ.addr == MEMK_INT_EN2_ADDR) begin
        rdata_d = int_en_q;
      end else if (I_REG_REQ.addr == MEMK_EVT_EN_ADDR) begin
        rdata_d = evt_en_q;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      int_en_q <= MEMK_INT_EN2_RESET;
      evt_en_q <= MEMK_EVT_EN_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      int_en_q <= int_en_d;
      evt_en_q <= evt_en_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_REG_RDATA = rdata_q;

  // Per-output sign holders.
  genvar g;
  generate
    for (g = 0; g < MEMK_NUM_PULSE; g++) begin : g_pulse
      memk_pulse_sign u_sign (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_pulse(I_PULSE_OUT[g]),
        .i_negative(I_PULSE_NEGATIVE[g]),
        .o_negative(pulse_neg[g])
      );
    end
  endgenerate

  // Any-phase summaries, order: fundamental reactive, apparent, reactive, active.
  assign nl_any = {|I_NOLOAD.freact, |I_NOLOAD.app, |I_NOLOAD.react, |I_NOLOAD.act};
  // A change on any single phase counts, even if another phase keeps the summary level.
  assign nl_change = {|(I_NOLOAD.freact ^ noload_q.freact), |(I_NOLOAD.app ^ noload_q.app),
                      |(I_NOLOAD.react ^ noload_q.react), |(I_NOLOAD.act ^ noload_q.act)};

  // Interrupt is a one-cycle low pulse per entry or exit; the timeout asserts while it holds.
  always_comb begin
    irq_d = 1'b0;
    if (int_en_q[MEMK_IE_ZXTO_A] && I_ZX_TIMEOUT_A) begin
      irq_d = 1'b1;
    end
    if ((int_en_q[MEMK_IE_FREACT_NL] && nl_change[3]) ||
        (int_en_q[MEMK_IE_APP_NL] && nl_change[2]) ||
        (int_en_q[MEMK_IE_REACT_NL] && nl_change[1]) ||
        (int_en_q[MEMK_IE_ACT_NL] && nl_change[0])) begin
      irq_d = 1'b1;
    end
  end

  // Event pin follows the enabled conditions as levels.
  always_comb begin
    event_d = 1'b0;
    if (evt_en_q[MEMK_EV_WAVE_RDY] && I_WAVE_READY) begin
      event_d = 1'b1;
    end
    if (evt_en_q[MEMK_EV_FREACT_NL] && nl_any[3]) begin
      event_d = 1'b1;
    end
    if ((evt_en_q[MEMK_EV_APP_NL] && nl_any[2]) ||
        (evt_en_q[MEMK_EV_REACT_NL] && nl_any[1]) ||
        (evt_en_q[MEMK_EV_ACT_NL] && nl_any[0])) begin
      event_d = 1'b1;
    end
    if (|(evt_en_q[MEMK_EV_PULSE_LO +: MEMK_NUM_PULSE] & pulse_neg)) begin
      event_d = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      noload_q <= '0;
      irq_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      noload_q <= I_NOLOAD;
      irq_q <= irq_d;
      event_q <= event_d;
    end
  end

  assign O_IRQ_N = ~irq_q;
  assign O_EVENT_N = ~event_q;

endmodule : memk_event_mask

// ---- hw/memk_pkg.sv ----
// Package with register map, field positions and carrier types for the event mask logic.
package memk_pkg;

  // Register word indices.
  localparam logic [11:0] MEMK_INT_EN2_ADDR = 12'h406;
  localparam logic [11:0] MEMK_EVT_EN_ADDR = 12'h407;

  // Second interrupt-enable register fields.
  localparam int MEMK_IE_ZXTO_A = 6;
  localparam int MEMK_IE_FREACT_NL = 4;
  localparam int MEMK_IE_APP_NL = 2;
  localparam int MEMK_IE_REACT_NL = 1;
  localparam int MEMK_IE_ACT_NL = 0;
  localparam logic [31:0] MEMK_INT_EN2_WMASK = 32'h0000_0057;
  localparam logic [31:0] MEMK_INT_EN2_RESET = 32'h0000_0000;

  // Event-pin enable register fields.
  localparam int MEMK_EV_WAVE_RDY = 16;
  localparam int MEMK_EV_FREACT_NL = 14;
  localparam int MEMK_EV_APP_NL = 12;
  localparam int MEMK_EV_REACT_NL = 11;
  localparam int MEMK_EV_ACT_NL = 10;
  localparam int MEMK_EV_PULSE_LO = 6;
  localparam logic [31:0] MEMK_EVT_EN_WMASK = 32'h0001_5FC0;
  localparam logic [31:0] MEMK_EVT_EN_RESET = 32'h0000_0000;

  localparam int MEMK_NUM_PULSE = 4;

  // No-load state of each phase for each energy kind, bit 0 is phase A.
  typedef struct packed {
    logic [2:0] freact;
    logic [2:0] app;
    logic [2:0] react;
    logic [2:0] act;
  } memk_noload_t;

  // Register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } memk_reg_req_t;

endpackage : memk_pkg

// ---- hw/memk_pulse_sign.sv ----
// Per-pulse-output negative-energy indication, refreshed on each falling edge of the output.
`timescale 1ns/100ps
module memk_pulse_sign
  import memk_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pulse output and sign of the energy behind it
  input wire logic i_pulse,
  input wire logic i_negative,
  // Held indication
  output logic o_negative
);

  logic pulse_q;
  logic pulse_d;
  logic neg_q;
  logic neg_d;

  always_comb begin
    pulse_d = i_pulse;
    neg_d = neg_q;
    // Only a high-to-low edge samples the sign; otherwise the last value holds.
    if (pulse_q && !i_pulse) begin
      neg_d = i_negative;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
      neg_q <= neg_d;
    end
  end

  assign o_negative = neg_q;

endmodule : memk_pulse_sign

// ---- verification/memk_event_mask_assertions.sv ----
// Port-level assertions for the event mask logic.
`timescale 1ns/100ps
module memk_event_mask_assertions
  import memk_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire memk_reg_req_t i_reg_req,
  input wire logic i_zx_timeout_a,
  input wire logic i_wave_ready,
  input wire memk_noload_t i_noload,
  input wire logic [MEMK_NUM_PULSE-1:0] i_pulse_out,
  input wire logic [MEMK_NUM_PULSE-1:0] i_pulse_negative,
  input wire logic o_irq_n,
  input wire logic o_event_n
);
  logic [31:0] ie_q, ie_d, ev_q, ev_d;
  // Shadow enables, so each check knows which conditions may reach the pins.
  always_comb begin
    ie_d = ie_q;
    ev_d = ev_q;
    if (i_reg_req.wr && i_reg_req.addr == MEMK_INT_EN2_ADDR) ie_d = i_reg_req.wdata & 32'h57;
    if (i_reg_req.wr && i_reg_req.addr == MEMK_EVT_EN_ADDR) ev_d = i_reg_req.wdata & 32'h15FC0;
  end
  always_ff @(posedge I_CLK) begin
    ie_q <= I_SYS_RST ? '0 : ie_d;
    ev_q <= I_SYS_RST ? '0 : ev_d;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_neg_fall;
    $fell(i_pulse_out[3]) && i_pulse_negative[3] && ev_q[9] ##1 ev_q[9] [*2];
  endsequence
  a_zxto_irq: assert property (ie_q[6] && i_zx_timeout_a |=> !o_irq_n)
    else $error("timeout irq missing");
  a_noload_irq: assert property (ie_q[0] && $changed(i_noload.act) |=> !o_irq_n)
    else $error("noload irq missing");
  a_irq_quiet: assert property (ie_q == 0 |=> o_irq_n)
    else $error("irq while masked");
  a_wave_event: assert property (ev_q[16] && i_wave_ready |=> !o_event_n)
    else $error("sample event missing");
  a_freact_event: assert property (ev_q[14] && |i_noload.freact |=> !o_event_n)
    else $error("freact event missing");
  a_act_event: assert property (ev_q[10] && |i_noload.act |=> !o_event_n)
    else $error("active event missing");
  a_pulse_event: assert property (s_neg_fall |=> !o_event_n)
    else $error("pulse sign event missing");
  a_event_quiet: assert property (ev_q == 0 |=> o_event_n)
    else $error("event while masked");
endmodule : memk_event_mask_assertions
bind memk_event_mask memk_event_mask_assertions chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .i_reg_req(I_REG_REQ), .i_zx_timeout_a(I_ZX_TIMEOUT_A), .i_wave_ready(I_WAVE_READY),
  .i_noload(I_NOLOAD), .i_pulse_out(I_PULSE_OUT), .i_pulse_negative(I_PULSE_NEGATIVE),
  .o_irq_n(O_IRQ_N), .o_event_n(O_EVENT_N));

// ---- verification/memk_event_mask_tb.sv ----
// Self-checking testbench for the event mask logic.
`timescale 1ns/100ps
module memk_event_mask_tb;
  import memk_pkg::*;
  logic clk = 0, rst = 1, zx = 0, wv = 0, irq_n, ev_n;
  logic [3:0] po = '0, pn = '0;
  logic [31:0] rdat;
  memk_reg_req_t rq = '0;
  memk_noload_t nl = '0;
  int failures = 0, n_tests = 0, irqs;
  memk_event_mask dut (.I_CLK(clk), .I_SYS_RST(rst), .I_REG_REQ(rq), .O_REG_RDATA(rdat),
    .I_ZX_TIMEOUT_A(zx), .I_WAVE_READY(wv), .I_NOLOAD(nl), .I_PULSE_OUT(po),
    .I_PULSE_NEGATIVE(pn), .O_IRQ_N(irq_n), .O_EVENT_N(ev_n));
  memk_host_model host (.i_clk(clk), .i_irq_n(irq_n), .o_irq_cnt(irqs));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n = 1);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    rq = '{wr: w, rd: !w, addr: a, wdata: d};
    step();
    rq = '0;
    // One idle edge, so a following access never re-raises the strobe in the same time step.
    step();
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    acc(0, a, '0);
    chk(rdat, exp);
  endtask : rd
  task automatic t_regs;
    rd(MEMK_INT_EN2_ADDR, 32'h0);
    rd(MEMK_EVT_EN_ADDR, 32'h0);
    acc(1, MEMK_INT_EN2_ADDR, '1);
    rd(MEMK_INT_EN2_ADDR, 32'h57);
    acc(1, MEMK_EVT_EN_ADDR, '1);
    rd(MEMK_EVT_EN_ADDR, 32'h15FC0);
    rd(12'h408, 32'h0);
  endtask : t_regs
  task automatic t_wave;
    acc(1, MEMK_EVT_EN_ADDR, 32'h10000);
    wv = 1;
    step();
    chk(ev_n, 0);
    wv = 0;
    step();
    chk(ev_n, 1);
  endtask : t_wave
  task automatic t_noload;
    int ib[4] = '{0, 1, 2, 4};
    int eb[4] = '{10, 11, 12, 14};
    int c0;
    c0 = irqs;
    for (int g = 0; g < 4; g++) begin
      acc(1, MEMK_INT_EN2_ADDR, 32'h1 << ib[g]);
      acc(1, MEMK_EVT_EN_ADDR, 32'h1 << eb[g]);
      nl = 12'h2 << (3 * g);
      step();
      chk({irq_n, ev_n}, 2'b00);
      nl = '0;
      step();
      chk(irq_n, 0);
      step();
      chk({irq_n, ev_n}, 2'b11);
    end
    chk(irqs - c0, 8);
  endtask : t_noload
  task automatic t_timeout;
    acc(1, MEMK_INT_EN2_ADDR, 32'h40);
    zx = 1;
    step(2);
    chk(irq_n, 0);
    acc(1, MEMK_INT_EN2_ADDR, 32'h0);
    step();
    chk(irq_n, 1);
    zx = 0;
  endtask : t_timeout
  task automatic t_pulse;
    // Every pulse output in turn, each with only its own enable bit set.
    for (int k = 0; k < 4; k++) begin
      acc(1, MEMK_EVT_EN_ADDR, 32'h40 << k);
      po[k] = 1;
      pn[k] = 1;
      step();
      po[k] = 0;
      step(3);
      chk(ev_n, 0);
      pn[k] = 0;
      step(3);
      chk(ev_n, 0);
      po[k] = 1;
      step();
      po[k] = 0;
      step(3);
      chk(ev_n, 1);
    end
  endtask : t_pulse
  task automatic give_verdict;
    $display("failures %0d of n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    step(5);
    rst = 0;
    t_regs();
    t_wave();
    t_noload();
    t_timeout();
    t_pulse();
    give_verdict();
  end
  // The tests need about 110 cycles, so 1000 cycles means a hang.
  initial begin
    #100us;
    failures++;
    give_verdict();
  end
endmodule : memk_event_mask_tb

// ---- verification/memk_host_model.sv ----
// Host model that counts the clock cycles in which the interrupt line is low.
`timescale 1ns/100ps
module memk_host_model (
  input wire logic i_clk,
  input wire logic i_irq_n,
  output int o_irq_cnt
);
  initial o_irq_cnt = 0;
  always @(posedge i_clk) if (!i_irq_n) o_irq_cnt++;
endmodule : memk_host_model
